// ---- src/key_scan_defines.svh ----
`ifndef KEY_SCAN_DEFINES_SVH
`define KEY_SCAN_DEFINES_SVH
// ==========================
// matrix geometry
`define KS_COLS 8
`define KS_ROWS 16
`define KS_IDLE_COLS 8'hff
`define KS_COL_ONE 8'h01
// rows 10..15 of the last column sit on unwired treble positions
`define KS_LAST_COL 3'h7
`define KS_LAST_COL_MASK 16'h03ff
`define KS_FULL_MASK 16'hffff
// ==========================
// timing
`define KS_CLK_KHZ 25000
`define KS_SCAN_US 250
`define KS_SCAN_CYC (`KS_SCAN_US * `KS_CLK_KHZ / 1000)
`define KS_SETTLE_NS 2000
`define KS_SETTLE_CYC ((`KS_SETTLE_NS * `KS_CLK_KHZ + 999999) / 1000000)
`define KS_BAUD_HZ 31250
`define KS_BIT_CYC (`KS_CLK_KHZ * 1000 / `KS_BAUD_HZ)
// ==========================
// serial frame
`define KS_FRAME_BITS 4'ha
`define KS_LINE_IDLE 10'h3ff
`define KS_RX_LAST 4'h9
`endif

// ---- src/key_scan_pkg.sv ----
package key_scan_pkg;
  typedef enum logic [1:0] {
    st_boot = 2'b00,
    st_scan = 2'b01,
    st_bus = 2'b10
  } mode_e;

  typedef struct packed {
    mode_e mode;
    logic [2:0] col;
    logic [12:0] step;
    logic [7:0][15:0] image;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [9:0] tx_cnt;
    logic rx_busy;
    logic [3:0] rx_bits;
    logic [9:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic key_error;
    logic [6:0] err_key;
    logic [7:0] dbg_rdata;
  } scan_s;
endpackage

// ---- src/key_matrix_scanner.sv ----
// Summary of operation
// - keyboard is one matrix of 8 driven columns by 16 sensed rows.
// - columns come from one 8-bit port, rows from two 8-bit ports.
// - while scanning, one column is low and the other seven high.
// - a low row means a closed contact, high means open.
// - select each column in turn, read all sixteen rows, then move on.
// - whole scan repeats every 250 us; key image kept in internal memory.
// - 61 keys; unwired treble positions never report a closure.
// - strap open at start gives bus mode: rows address, columns data.
// - scanner and engine exchange serial messages both ways at 31.25 kbaud.
// - scanner shares its reset with engine and effects processor.
// - flag key error when lower contact closed but upper contact open.
`timescale 1ns/1ns
`default_nettype none
`include "key_scan_defines.svh"

module key_matrix_scanner
  import key_scan_pkg::*;
#(
  parameter int unsigned SCAN_CYC = `KS_SCAN_CYC,
  parameter int unsigned SETTLE_CYC = `KS_SETTLE_CYC,
  parameter int unsigned BIT_CYC = `KS_BIT_CYC
) (
  // clock and shared reset
  input wire logic sys_clk,
  input wire logic reset,
  // mode strap, high when open
  input wire logic bus_mode_strap,
  // column port: scan drive or debug data bus
  input wire logic [7:0] col_in,
  output logic [7:0] col_out,
  output logic [7:0] col_oe,
  // row ports: scan sense or debug address bus
  input wire logic [7:0] row_lo_in,
  input wire logic [7:0] row_hi_in,
  output logic [15:0] row_out,
  output logic row_oe,
  // debug bus requests
  input wire logic [15:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  input wire logic dbg_we,
  output logic [7:0] dbg_rdata,
  // serial link to engine
  output logic tx_out,
  input wire logic rx_in,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // key error report
  output logic key_error,
  output logic [6:0] err_key
);

  localparam int unsigned STEP_CYC = SCAN_CYC / `KS_COLS;
  localparam logic [12:0] STEP_LAST = 13'(STEP_CYC - 1);
  localparam logic [12:0] SETTLE_AT = 13'(SETTLE_CYC);
  localparam logic [9:0] BIT_LAST = 10'(BIT_CYC - 1);
  localparam logic [9:0] BIT_HALF = 10'(BIT_CYC / 2);

  scan_s s;
  scan_s next_s;
  logic [15:0] live;
  logic [15:0] diff;
  logic [3:0] sel;
  logic tx_load;

  // ==========================
  // next state
  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.key_error = 1'b0;
    tx_load = 1'b0;
    sel = 4'h0;
    // closed contact reads low; unwired positions masked off
    live = ~{row_hi_in, row_lo_in};
    if (s.col == `KS_LAST_COL) begin
      live = live & `KS_LAST_COL_MASK;
    end else begin
      live = live & `KS_FULL_MASK;
    end
    diff = live ^ s.image[s.col];
    for (int i = `KS_ROWS - 1; i >= 0; i--) begin
      if (diff[i]) begin
        sel = 4'(i);
      end
    end
    case (s.mode)
      st_boot: begin
        // strap caught once, after reset release
        next_s.mode = bus_mode_strap ? st_bus : st_scan;
      end
      st_scan: begin
        if (s.step == STEP_LAST) begin
          next_s.step = 13'h0000;
          next_s.col = s.col + 3'h1;
        end else begin
          next_s.step = s.step + 13'h0001;
        end
        // sample only once the column has settled
        if (s.step == SETTLE_AT) begin
          for (int k = 0; k < `KS_ROWS / 2; k++) begin
            // even row upper contact, odd row lower contact
            if (live[2*k+1] && !live[2*k]) begin
              next_s.key_error = 1'b1;
              next_s.err_key = {s.col, 4'(2*k)};
            end
          end
          if (diff != 16'h0000 && s.tx_bits == 4'h0) begin
            // one change per sample; the rest wait for a later pass
            tx_load = 1'b1;
            next_s.image[s.col][sel] = live[sel];
            next_s.tx_sh = {1'b1, live[sel], s.col, sel, 1'b0};
            next_s.tx_bits = `KS_FRAME_BITS;
            next_s.tx_cnt = 10'h000;
          end
        end
      end
      st_bus: begin
        next_s.dbg_rdata = col_in;
      end
      default: begin
        next_s.mode = st_boot;
      end
    endcase
    // transmitter, lsb first after start bit
    if (s.tx_bits != 4'h0) begin
      if (s.tx_cnt == BIT_LAST) begin
        next_s.tx_cnt = 10'h000;
        next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
        next_s.tx_bits = s.tx_bits - 4'h1;
      end else begin
        next_s.tx_cnt = s.tx_cnt + 10'h001;
      end
    end
    // receiver, samples mid bit
    if (!s.rx_busy) begin
      if (!rx_in) begin
        next_s.rx_busy = 1'b1;
        next_s.rx_bits = 4'h0;
        next_s.rx_cnt = BIT_LAST - BIT_HALF;
      end
    end else if (s.rx_cnt == BIT_LAST) begin
      next_s.rx_cnt = 10'h000;
      next_s.rx_bits = s.rx_bits + 4'h1;
      if (s.rx_bits == 4'h0) begin
        // false start: line back high at mid bit
        next_s.rx_busy = !rx_in;
      end else if (s.rx_bits == `KS_RX_LAST) begin
        next_s.rx_busy = 1'b0;
        if (rx_in) begin
          next_s.rx_data = s.rx_sh;
          next_s.rx_valid = 1'b1;
        end
      end else begin
        next_s.rx_sh = {rx_in, s.rx_sh[7:1]};
      end
    end else begin
      next_s.rx_cnt = s.rx_cnt + 10'h001;
    end
  end

  // ==========================
  // state register, reset shared with engine, clock from engine
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.mode <= st_boot;
      s.tx_sh <= `KS_LINE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================
  // pins
  always_comb begin
    col_out = `KS_IDLE_COLS;
    col_oe = 8'h00;
    row_out = 16'h0000;
    row_oe = 1'b0;
    if (s.mode == st_scan) begin
      col_out = ~(`KS_COL_ONE << s.col);
      col_oe = `KS_IDLE_COLS;
    end else if (s.mode == st_bus) begin
      row_out = dbg_addr;
      row_oe = 1'b1;
      col_out = dbg_wdata;
      col_oe = {8{dbg_we}};
    end
  end

  assign tx_out = s.tx_sh[0];
  assign rx_data = s.rx_data;
  assign rx_valid = s.rx_valid;
  assign key_error = s.key_error;
  assign err_key = s.err_key;
  assign dbg_rdata = s.dbg_rdata;

  // ==========================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_ONE_COL_LOW: assert property (
    s.mode == st_scan |-> $countones(col_out) == 7 && col_oe == 8'hff)
    else $error("scan must hold exactly one column low");
  AST_COL_HOLD: assert property (
    s.mode == st_scan && s.step != STEP_LAST |=> $stable(s.col))
    else $error("column changed before its step ended");
  AST_COL_ADV: assert property (
    s.mode == st_scan && s.step == STEP_LAST |=> s.col == $past(s.col) + 3'h1)
    else $error("column did not advance at step end");
  AST_ROWS_SENSE: assert property (
    s.mode == st_scan |-> !row_oe)
    else $error("row port driven while scanning");
  AST_UNWIRED: assert property (
    s.image[`KS_LAST_COL][15:10] == 6'h00)
    else $error("unwired position reported closed");
  AST_BUS_MODE: assert property (
    s.mode == st_boot && bus_mode_strap |=> s.mode == st_bus && row_oe)
    else $error("open strap did not enter bus mode");
  AST_TX_START: assert property (
    tx_load |=> !tx_out [*8])
    else $error("start bit not held after load");
  AST_SETTLE: assert property (
    tx_load |-> col_out == $past(col_out, SETTLE_CYC))
    else $error("rows sampled before settling");
  AST_KEY_ERR: assert property (
    s.mode == st_scan && s.step == SETTLE_AT && !row_lo_in[1] && row_lo_in[0]
    |=> key_error)
    else $error("lower-only closure not flagged");
  AST_REPORT_CHANGE: assert property (
    tx_load |=> s.image != $past(s.image))
    else $error("report sent without image change");
  AST_OPEN_QUIET: assert property (
    s.mode == st_scan && {row_hi_in, row_lo_in} == 16'hffff && s.image[s.col] == 16'h0
    |-> !tx_load)
    else $error("open rows produced a report");

  // ==========================
  // mode, bus, scan, key error and serial checks
  AST_BOOT_IDLE: assert property (
    s.mode == st_boot |-> col_oe == 8'h00 && col_out == `KS_IDLE_COLS && !row_oe)
    else $error("pins driven before mode was chosen");
  AST_SCAN_ENTRY: assert property (
    s.mode == st_boot && !bus_mode_strap
    |=> s.mode == st_scan && s.col == 3'h0 && s.step == 13'h0000)
    else $error("closed strap did not start scanning at column zero");
  AST_MODE_FIXED: assert property (
    s.mode != st_boot |=> $stable(s.mode))
    else $error("mode changed without reset");
  AST_STEP_RANGE: assert property (
    s.mode == st_scan |-> s.step <= STEP_LAST)
    else $error("step counter ran past the column slot");
  AST_COL_DRIVE: assert property (
    s.mode == st_scan |-> !col_out[s.col])
    else $error("selected column not driven low");
  AST_ROW_ADDR: assert property (
    s.mode == st_bus |-> row_oe && row_out == dbg_addr)
    else $error("row ports not carrying the address");
  AST_DATA_BUS: assert property (
    s.mode == st_bus |-> col_oe == {8{dbg_we}} && (!dbg_we || col_out == dbg_wdata))
    else $error("column port not carrying write data");
  AST_BUS_READ: assert property (
    s.mode == st_bus |=> dbg_rdata == $past(col_in))
    else $error("read data not taken from the column port");
  AST_TX_IDLE: assert property (
    s.tx_bits == 4'h0 |-> tx_out)
    else $error("serial line low while idle");
  AST_TX_STOP: assert property (
    s.tx_bits == 4'h1 |-> tx_out)
    else $error("stop bit not high");
  AST_RX_STOP: assert property (
    rx_valid |-> $past(rx_in))
    else $error("byte accepted without a high stop bit");
  AST_RX_HOLD: assert property (
    !rx_valid |-> $stable(rx_data))
    else $error("received byte changed without a pulse");
  AST_RX_FRAME: assert property (
    rx_valid |-> !s.rx_busy)
    else $error("receiver still busy after a byte");
  AST_RX_ABORT: assert property (
    s.rx_busy && s.rx_bits == 4'h0 && s.rx_cnt == BIT_LAST && rx_in |=> !s.rx_busy)
    else $error("false start not abandoned");
  AST_ERR_PAIR: assert property (
    key_error |-> $past(s.mode) == st_scan && $past(s.step) == SETTLE_AT
      && $past(s.col) == err_key[6:4])
    else $error("key error outside a column sample");
  AST_ERR_ROW: assert property (
    key_error |-> !err_key[0])
    else $error("key error not named by its upper row");
  AST_NO_FALSE_ERR: assert property (
    s.mode == st_scan && s.step == SETTLE_AT && {row_hi_in, row_lo_in} == `KS_FULL_MASK
    |=> !key_error)
    else $error("key error with every contact open");
  AST_IMAGE_HOLD: assert property (
    !tx_load |=> $stable(s.image))
    else $error("key image changed without a report");

  COV_REPORT: cover property (tx_load);
  COV_ERROR: cover property (key_error);
  COV_RX: cover property (rx_valid);
  COV_BUS: cover property (s.mode == st_bus && dbg_we);
  COV_WRAP: cover property (s.mode == st_scan && s.col == `KS_LAST_COL && s.step == STEP_LAST);

endmodule // key_matrix_scanner
`default_nettype wire

// ---- verif/key_matrix_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====
// keyswitch matrix, rows pulled up
module key_matrix_model (
  // column drive
  input wire logic [7:0] col_drv,
  input wire logic [7:0] col_en,
  // closed contacts, col*16+row
  input wire logic [127:0] closed,
  // row lines
  output logic [15:0] rows
);
  always_comb begin
    rows = 16'hffff;
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 16; r++) begin
        if (col_en[c] && !col_drv[c] && closed[c * 16 + r]) begin
          rows[r] = 1'b0;
        end
      end
    end
  end
endmodule // key_matrix_model
`default_nettype wire

// ---- verif/key_matrix_scanner_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module key_matrix_scanner_tb;
  localparam int BIT = 16;
  logic sys_clk = 0, reset = 1, strap = 0, dbg_we = 0, rx_in = 1, row_oe, tx_out;
  logic rx_valid, key_error, seen;
  logic [7:0] col_in = 8'h00, dbg_wdata = 8'h00, col_out, col_oe, dbg_rdata, rx_data, b;
  logic [15:0] dbg_addr = 16'h0000, rows, row_out;
  logic [6:0] err_key;
  logic [127:0] closed = '0;
  int err_total = 0, comparisons = 0;
  key_matrix_scanner #(.SCAN_CYC(400), .SETTLE_CYC(4), .BIT_CYC(BIT)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .bus_mode_strap(strap), .col_in(col_in),
    .col_out(col_out), .col_oe(col_oe), .row_lo_in(rows[7:0]), .row_hi_in(rows[15:8]),
    .row_out(row_out), .row_oe(row_oe), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .dbg_we(dbg_we), .dbg_rdata(dbg_rdata), .tx_out(tx_out), .rx_in(rx_in),
    .rx_data(rx_data), .rx_valid(rx_valid), .key_error(key_error), .err_key(err_key));
  key_matrix_model i_keys (.col_drv(col_out), .col_en(col_oe), .closed(closed), .rows(rows));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // ====
  // helpers
  task automatic stop_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic hang(input string n);
    err_total++;
    $display("MISMATCH %s exp event got timeout", n);
    stop_test();
  endtask
  task automatic get_byte(output logic [7:0] d);
    int i;
    for (i = 0; i < 2000 && tx_out !== 1'b0; i++) @(posedge sys_clk);
    if (tx_out !== 1'b0) hang("tx start");
    tick(BIT / 2);
    for (i = 0; i < 8; i++) begin
      tick(BIT);
      d[i] = tx_out;
    end
    tick(BIT);
    `CHK("stop bit", 1'b1, tx_out)
    tick(BIT / 2);
  endtask
  task automatic quiet(input string n);
    logic low;
    low = 1'b0;
    repeat (900) begin
      @(posedge sys_clk);
      low = low | (tx_out !== 1'b1);
    end
    `CHK(n, 1'b0, low)
  endtask
  task automatic send(input logic [7:0] d, input logic stop);
    seen = 1'b0;
    rx_in <= 1'b0;
    tick(BIT);
    for (int i = 0; i < 8; i++) begin
      rx_in <= d[i];
      tick(BIT);
    end
    rx_in <= stop;
    for (int i = 0; i < 3 * BIT; i++) begin
      if (i == BIT) rx_in <= 1'b1;
      @(posedge sys_clk);
      if (rx_valid === 1'b1) seen = 1'b1;
    end
  endtask
  // ====
  // scenarios
  task automatic t_scan();
    int i;
    for (i = 0; i < 100 && col_out !== 8'hfe; i++) @(posedge sys_clk);
    if (col_out !== 8'hfe) hang("column 0");
    tick(25);
    for (int c = 0; c < 9; c++) begin
      `CHK("column", ~(8'h01 << (c % 8)), col_out)
      `CHK("col_oe", 8'hff, col_oe)
      `CHK("row_oe", 1'b0, row_oe)
      tick(50);
    end
  endtask
  task automatic t_keys();
    int i;
    closed[36] <= 1'b1;
    get_byte(b);
    `CHK("press", 8'ha4, b)
    quiet("repeat");
    closed[36] <= 1'b0;
    get_byte(b);
    `CHK("release", 8'h24, b)
    closed[53] <= 1'b1;
    for (i = 0; i < 900 && key_error !== 1'b1; i++) @(posedge sys_clk);
    `CHK("key_error", 1'b1, key_error)
    `CHK("err_key", 7'h34, err_key)
    get_byte(b);
    `CHK("lower", 8'hb5, b)
    closed[53] <= 1'b0;
    get_byte(b);
    `CHK("lower off", 8'h35, b)
    closed[124] <= 1'b1;
    quiet("unwired");
    closed[124] <= 1'b0;
    closed[120] <= 1'b1;
    get_byte(b);
    `CHK("last wired", 8'hf8, b)
    closed[120] <= 1'b0;
    get_byte(b);
    `CHK("last off", 8'h78, b)
  endtask
  task automatic t_rx();
    send(8'h5a, 1'b1);
    `CHK("rx_valid", 1'b1, seen)
    `CHK("rx_data", 8'h5a, rx_data)
    send(8'hc3, 1'b0);
    `CHK("bad stop", 1'b0, seen)
    `CHK("rx_data kept", 8'h5a, rx_data)
  endtask
  task automatic t_bus();
    reset <= 1'b1;
    strap <= 1'b1;
    tick(3);
    reset <= 1'b0;
    tick(3);
    dbg_addr <= 16'h1234;
    dbg_wdata <= 8'h5c;
    dbg_we <= 1'b1;
    tick(1);
    @(posedge sys_clk);
    `CHK("row_oe", 1'b1, row_oe)
    `CHK("row_out", 16'h1234, row_out)
    `CHK("col_oe", 8'hff, col_oe)
    `CHK("col_out", 8'h5c, col_out)
    dbg_we <= 1'b0;
    col_in <= 8'ha6;
    tick(3);
    `CHK("col_oe rd", 8'h00, col_oe)
    `CHK("dbg_rdata", 8'ha6, dbg_rdata)
  endtask
  initial begin
    tick(2);
    `CHK("col_oe rst", 8'h00, col_oe)
    `CHK("col_out rst", 8'hff, col_out)
    `CHK("tx_out rst", 1'b1, tx_out)
    tick(1);
    reset <= 1'b0;
    t_scan();
    t_keys();
    t_rx();
    t_bus();
    stop_test();
  end
endmodule // key_matrix_scanner_tb
`default_nettype wire
